// >>> hw/psmc_pkg.sv
package psmc_pkg;
	localparam int DATA_W = 32;
	localparam int ID_W = 16;
	localparam int N_PARAM = 16;
	localparam int IDX_W = 4;
	localparam int HIST_DEPTH = 10;
	localparam int HIST_IDX_W = 4;
	localparam int N_DRV = 4;

	// Command and register IDs
	localparam logic [ID_W-1:0] ID_PROTECT_KEY = 16'h0022;
	localparam logic [ID_W-1:0] ID_ALARM_RESET = 16'h00c0;
	localparam logic [ID_W-1:0] ID_ALARM_HIST_CLEAR = 16'h00c2;
	localparam logic [ID_W-1:0] ID_ORIGIN_PRESET = 16'h00c5;
	localparam logic [ID_W-1:0] ID_RECONFIGURE = 16'h00c6;
	localparam logic [ID_W-1:0] ID_INIT_KEEP_MECH_COMM = 16'h00c7;
	localparam logic [ID_W-1:0] ID_NV_TO_RAM = 16'h00c8;
	localparam logic [ID_W-1:0] ID_RAM_TO_NV = 16'h00c9;
	localparam logic [ID_W-1:0] ID_INIT_KEEP_MECH = 16'h00ca;
	localparam logic [ID_W-1:0] ID_CMD_HIST_CLEAR = 16'h00ce;
	localparam logic [ID_W-1:0] ID_DRV_STOP_RELEASE = 16'h00d0;
	localparam logic [ID_W-1:0] ID_INFO_CLEAR = 16'h00d3;
	localparam logic [ID_W-1:0] ID_INFO_HIST_CLEAR = 16'h00d4;
	localparam logic [ID_W-1:0] ID_ALARM_DETAIL_SEL = 16'h00d5;
	localparam logic [ID_W-1:0] PARAM_ID_BASE = 16'h0100;

	// Values after reset, key and detail index limits
	localparam logic [DATA_W-1:0] PROTECT_KEY_RESET = 32'h0000_0000;
	localparam logic [DATA_W-1:0] PROTECT_KEY_VALUE = 32'h3389_0312;
	localparam logic [HIST_IDX_W-1:0] DETAIL_SEL_MIN = 4'h1;
	localparam logic [HIST_IDX_W-1:0] DETAIL_SEL_MAX = 4'ha;
	localparam logic [HIST_IDX_W-1:0] DETAIL_SEL_RESET = 4'h0;

	// Update classes, two bits per parameter index
	localparam logic [1:0] CLASS_A = 2'h0;
	localparam logic [1:0] CLASS_B = 2'h1;
	localparam logic [1:0] CLASS_C = 2'h2;
	localparam logic [1:0] CLASS_D = 2'h3;
	localparam logic [2*N_PARAM-1:0] PARAM_CLASS = 32'hffaa_5500;

	// Parameter groups, two bits per parameter index
	localparam logic [1:0] GROUP_GENERAL = 2'h0;
	localparam logic [1:0] GROUP_MECH = 2'h1;
	localparam logic [1:0] GROUP_COMM = 2'h2;
	localparam logic [2*N_PARAM-1:0] PARAM_GROUP = 32'h0000_00a5;
	localparam logic [N_PARAM*DATA_W-1:0] PARAM_DEFAULTS = {N_PARAM{32'h0000_0000}};

	localparam logic [IDX_W-1:0] IDX_LAST = 4'hf;
	localparam logic [IDX_W-1:0] IDX_FIRST = 4'h0;

	typedef enum logic [2:0] {
		ST_IDLE = 3'b000,
		ST_LOAD = 3'b001,
		ST_APPLY = 3'b011,
		ST_STORE = 3'b010,
		ST_INIT = 3'b110
	} psmc_state_t;
endpackage : psmc_pkg

// >>> hw/psmc_param_bank.sv
`timescale 1ns/1ps
module psmc_param_bank #(
	parameter int N = 16,
	parameter int W = 32,
	parameter int IW = 4,
	parameter bit CLEAR_ON_RESET = 1'b1
) (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic srst,
	// Write port
	input wire logic we,
	input wire logic [IW-1:0] wrIdx,
	input wire logic [W-1:0] wrData,
	// Contents
	output logic [N*W-1:0] words
);
	// Clears on reset unless CLEAR_ON_RESET is 0, which keeps the contents through reset
	always_ff @(posedge ref_clk) begin
		if (srst && CLEAR_ON_RESET) begin
			words <= '0;
		end else if (we) begin
			words[int'(wrIdx)*W +: W] <= wrData;
		end
	end
endmodule : psmc_param_bank

// >>> hw/psmc_history.sv
`timescale 1ns/1ps
module psmc_history #(
	parameter int DEPTH = 10,
	parameter int W = 32
) (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic srst,
	// Events
	input wire logic push,
	input wire logic [W-1:0] pushData,
	input wire logic clear,
	// Entry 0 is the newest
	output logic [DEPTH*W-1:0] entries
);
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			entries <= '0;
		end else if (push && clear) begin
			// New entry survives a clear in the same cycle
			entries <= {{((DEPTH-1)*W){1'b0}}, pushData};
		end else if (push) begin
			entries <= {entries[(DEPTH-1)*W-1:0], pushData};
		end else if (clear) begin
			entries <= '0;
		end
	end
endmodule : psmc_history

// >>> hw/psmc_param_store.sv
`timescale 1ns/1ps
module psmc_param_store (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic srst,
	// Host write port
	input wire logic cmdValid,
	input wire logic [psmc_pkg::ID_W-1:0] cmdId,
	input wire logic [psmc_pkg::DATA_W-1:0] cmdData,
	// Machine status
	input wire logic opStopped,
	input wire logic [psmc_pkg::DATA_W-1:0] tcpPosition,
	input wire logic [psmc_pkg::N_DRV-1:0] driverExcluded,
	// Alarm and information sources
	input wire logic alarmEvent,
	input wire logic [psmc_pkg::DATA_W-1:0] alarmCodeIn,
	input wire logic alarmNonResettable,
	input wire logic infoEvent,
	input wire logic [psmc_pkg::DATA_W-1:0] infoCodeIn,
	// Command status
	output logic busy,
	output logic cmdDone,
	output logic cmdRefused,
	// Applied, RAM and non-volatile parameters
	output logic [psmc_pkg::N_PARAM*psmc_pkg::DATA_W-1:0] appliedParams,
	output logic [psmc_pkg::N_PARAM*psmc_pkg::DATA_W-1:0] ramParams,
	output logic [psmc_pkg::N_PARAM*psmc_pkg::DATA_W-1:0] nvParams,
	// Protection
	output logic toolUnlocked,
	// Alarm, information and command state
	output logic alarmActive,
	output logic [psmc_pkg::DATA_W-1:0] presentAlarm,
	output logic infoActive,
	output logic [psmc_pkg::DATA_W-1:0] presentInfo,
	output logic [psmc_pkg::HIST_DEPTH*psmc_pkg::DATA_W-1:0] alarmHistory,
	output logic [psmc_pkg::HIST_DEPTH*psmc_pkg::DATA_W-1:0] infoHistory,
	output logic [psmc_pkg::HIST_DEPTH*psmc_pkg::DATA_W-1:0] commandHistory,
	output logic [psmc_pkg::DATA_W-1:0] alarmDetail,
	// Maintenance actions
	output logic [psmc_pkg::DATA_W-1:0] userOrigin,
	output logic [psmc_pkg::N_DRV-1:0] driverStopRelease
);
	import psmc_pkg::*;

	psmc_state_t stateReg;
	logic [IDX_W-1:0] seqIdxReg;
	logic powerUpReg;
	logic keepCommReg;
	logic [DATA_W-1:0] protectKeyReg;
	logic [HIST_IDX_W-1:0] detailSelReg;
	logic [N_PARAM-1:0] pendingBReg;
	logic latchedAlarmReg;

	logic accept;
	logic paramWr;
	logic maintCmd;
	logic [IDX_W-1:0] paramIdx;
	logic [1:0] paramClass;
	logic [1:0] seqClass;
	logic [1:0] seqGroup;
	logic [DATA_W-1:0] seqRamWord;
	logic [DATA_W-1:0] seqNvWord;
	logic [DATA_W-1:0] seqDefault;
	logic ramWe;
	logic [IDX_W-1:0] ramIdx;
	logic [DATA_W-1:0] ramData;
	logic nvWe;
	logic [DATA_W-1:0] nvData;
	logic initSkip;
	logic cmdAlarmReset;
	logic cmdInfoClear;

	// Commands are taken only while the sequencer is idle
	assign accept = cmdValid && (stateReg == ST_IDLE);
	assign paramIdx = cmdId[IDX_W-1:0];
	assign paramWr = accept && (cmdId[ID_W-1:IDX_W] == PARAM_ID_BASE[ID_W-1:IDX_W]);
	assign paramClass = PARAM_CLASS[2*int'(paramIdx) +: 2];
	assign seqClass = PARAM_CLASS[2*int'(seqIdxReg) +: 2];
	assign seqGroup = PARAM_GROUP[2*int'(seqIdxReg) +: 2];
	assign seqRamWord = ramParams[int'(seqIdxReg)*DATA_W +: DATA_W];
	assign seqNvWord = nvParams[int'(seqIdxReg)*DATA_W +: DATA_W];
	assign seqDefault = PARAM_DEFAULTS[int'(seqIdxReg)*DATA_W +: DATA_W];
	assign cmdAlarmReset = accept && (cmdId == ID_ALARM_RESET);
	assign cmdInfoClear = accept && (cmdId == ID_INFO_CLEAR);

	always_comb begin
		maintCmd = 1'b0;
		if (accept) begin
			case (cmdId)
				ID_ALARM_RESET, ID_ALARM_HIST_CLEAR, ID_ORIGIN_PRESET, ID_RECONFIGURE,
				ID_INIT_KEEP_MECH_COMM, ID_NV_TO_RAM, ID_RAM_TO_NV, ID_INIT_KEEP_MECH,
				ID_CMD_HIST_CLEAR, ID_DRV_STOP_RELEASE, ID_INFO_CLEAR, ID_INFO_HIST_CLEAR,
				ID_ALARM_DETAIL_SEL: maintCmd = 1'b1;
				default: maintCmd = 1'b0;
			endcase
		end
	end

	always_comb begin
		initSkip = (seqGroup == GROUP_MECH);
		if (keepCommReg && (seqGroup == GROUP_COMM)) begin
			initSkip = 1'b1;
		end
	end

	always_comb begin
		ramWe = 1'b0;
		ramIdx = paramIdx;
		ramData = cmdData;
		if (stateReg == ST_LOAD) begin
			ramWe = 1'b1;
			ramIdx = seqIdxReg;
			ramData = seqNvWord;
		end else if (paramWr) begin
			ramWe = 1'b1;
		end
	end

	always_comb begin
		nvWe = 1'b0;
		nvData = seqRamWord;
		if (stateReg == ST_STORE) begin
			nvWe = 1'b1;
		end else if (stateReg == ST_INIT) begin
			nvWe = !initSkip;
			nvData = seqDefault;
		end
	end

	// One 32-bit word each
	// RAM is rebuilt from the image at every power-up anyway
	psmc_param_bank #(
		.N(N_PARAM),
		.W(DATA_W),
		.IW(IDX_W),
		.CLEAR_ON_RESET(1'b1)
	) ramBank (
		.ref_clk(ref_clk),
		.srst(srst),
		.we(ramWe),
		.wrIdx(ramIdx),
		.wrData(ramData),
		.words(ramParams)
	);

	// Emulates retention: reset leaves it alone
	psmc_param_bank #(
		.N(N_PARAM),
		.W(DATA_W),
		.IW(IDX_W),
		.CLEAR_ON_RESET(1'b0)
	) nvBank (
		.ref_clk(ref_clk),
		.srst(srst),
		.we(nvWe),
		.wrIdx(seqIdxReg),
		.wrData(nvData),
		.words(nvParams)
	);

	// Sequencer for batch memory work
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			stateReg <= ST_LOAD;
			seqIdxReg <= IDX_FIRST;
			powerUpReg <= 1'b1;
			keepCommReg <= 1'b0;
			busy <= 1'b1;
			cmdDone <= 1'b0;
		end else begin
			cmdDone <= 1'b0;
			case (stateReg)
				ST_IDLE: begin
					seqIdxReg <= IDX_FIRST;
					if (accept) begin
						case (cmdId)
							ID_RECONFIGURE: begin
								stateReg <= ST_APPLY;
								powerUpReg <= 1'b0;
								busy <= 1'b1;
							end
							ID_NV_TO_RAM: begin
								stateReg <= ST_LOAD;
								powerUpReg <= 1'b0;
								busy <= 1'b1;
							end
							ID_RAM_TO_NV: begin
								stateReg <= ST_STORE;
								busy <= 1'b1;
							end
							ID_INIT_KEEP_MECH_COMM: begin
								stateReg <= ST_INIT;
								keepCommReg <= 1'b1;
								busy <= 1'b1;
							end
							ID_INIT_KEEP_MECH: begin
								stateReg <= ST_INIT;
								keepCommReg <= 1'b0;
								busy <= 1'b1;
							end
							default: begin
								stateReg <= ST_IDLE;
								// Single-cycle commands finish here
								cmdDone <= maintCmd || paramWr || (cmdId == ID_PROTECT_KEY);
							end
						endcase
					end
				end
				ST_LOAD: begin
					seqIdxReg <= seqIdxReg + 4'h1;
					if (seqIdxReg == IDX_LAST) begin
						seqIdxReg <= IDX_FIRST;
						if (powerUpReg) begin
							stateReg <= ST_APPLY;
						end else begin
							stateReg <= ST_IDLE;
							busy <= 1'b0;
							cmdDone <= 1'b1;
						end
					end
				end
				ST_APPLY, ST_STORE, ST_INIT: begin
					seqIdxReg <= seqIdxReg + 4'h1;
					if (seqIdxReg == IDX_LAST) begin
						seqIdxReg <= IDX_FIRST;
						stateReg <= ST_IDLE;
						powerUpReg <= 1'b0;
						busy <= 1'b0;
						// Power-up apply is not a host command
						cmdDone <= !powerUpReg;
					end
				end
				default: begin
					stateReg <= ST_IDLE;
					busy <= 1'b0;
				end
			endcase
		end
	end

	always_ff @(posedge ref_clk) begin
		if (srst) begin
			cmdRefused <= 1'b0;
		end else begin
			cmdRefused <= cmdValid && (stateReg != ST_IDLE);
		end
	end

	// Effective parameter values
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			appliedParams <= '0;
			pendingBReg <= '0;
		end else begin
			if (opStopped) begin
				for (int i = 0; i < N_PARAM; i++) begin
					if (pendingBReg[i]) begin
						appliedParams[i*DATA_W +: DATA_W] <= ramParams[i*DATA_W +: DATA_W];
						pendingBReg[i] <= 1'b0;
					end
				end
			end
			if (stateReg == ST_APPLY) begin
				if (powerUpReg || (seqClass != CLASS_D)) begin
					appliedParams[int'(seqIdxReg)*DATA_W +: DATA_W] <= seqRamWord;
					pendingBReg[seqIdxReg] <= 1'b0;
				end
			end
			if (paramWr) begin
				if (paramClass == CLASS_A) begin
					appliedParams[int'(paramIdx)*DATA_W +: DATA_W] <= cmdData;
				end
				// Set wins over a same-cycle stop
				if (paramClass == CLASS_B) begin
					pendingBReg[paramIdx] <= 1'b1;
				end
			end
		end
	end

	always_ff @(posedge ref_clk) begin
		if (srst) begin
			protectKeyReg <= PROTECT_KEY_RESET;
			toolUnlocked <= 1'b0;
		end else if (accept && (cmdId == ID_PROTECT_KEY)) begin
			protectKeyReg <= cmdData;
			toolUnlocked <= (cmdData == PROTECT_KEY_VALUE);
		end
	end

	always_ff @(posedge ref_clk) begin
		if (srst) begin
			alarmActive <= 1'b0;
			presentAlarm <= '0;
		end else if (alarmEvent) begin
			// New alarm wins over a same-cycle reset
			alarmActive <= 1'b1;
			presentAlarm <= alarmCodeIn;
		end else if (cmdAlarmReset && !latchedAlarmReg) begin
			alarmActive <= 1'b0;
			presentAlarm <= '0;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (srst) begin
			latchedAlarmReg <= 1'b0;
		end else if (alarmEvent) begin
			latchedAlarmReg <= alarmNonResettable;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (srst) begin
			infoActive <= 1'b0;
			presentInfo <= '0;
		end else if (infoEvent) begin
			infoActive <= 1'b1;
			presentInfo <= infoCodeIn;
		end else if (cmdInfoClear) begin
			infoActive <= 1'b0;
			presentInfo <= '0;
		end
	end

	psmc_history #(
		.DEPTH(HIST_DEPTH),
		.W(DATA_W)
	) alarmHist (
		.ref_clk(ref_clk),
		.srst(srst),
		.push(alarmEvent),
		.pushData(alarmCodeIn),
		.clear(accept && (cmdId == ID_ALARM_HIST_CLEAR)),
		.entries(alarmHistory)
	);

	psmc_history #(
		.DEPTH(HIST_DEPTH),
		.W(DATA_W)
	) infoHist (
		.ref_clk(ref_clk),
		.srst(srst),
		.push(infoEvent),
		.pushData(infoCodeIn),
		.clear(accept && (cmdId == ID_INFO_HIST_CLEAR)),
		.entries(infoHistory)
	);

	psmc_history #(
		.DEPTH(HIST_DEPTH),
		.W(DATA_W)
	) cmdHist (
		.ref_clk(ref_clk),
		.srst(srst),
		.push(maintCmd),
		.pushData({{(DATA_W-ID_W){1'b0}}, cmdId}),
		.clear(accept && (cmdId == ID_CMD_HIST_CLEAR)),
		.entries(commandHistory)
	);

	always_ff @(posedge ref_clk) begin
		if (srst) begin
			detailSelReg <= DETAIL_SEL_RESET;
		end else if (accept && (cmdId == ID_ALARM_DETAIL_SEL)) begin
			// Out-of-range index keeps the old choice
			if ((cmdData >= 32'(DETAIL_SEL_MIN)) && (cmdData <= 32'(DETAIL_SEL_MAX))) begin
				detailSelReg <= cmdData[HIST_IDX_W-1:0];
			end
		end
	end

	always_ff @(posedge ref_clk) begin
		if (srst) begin
			alarmDetail <= '0;
		end else if (detailSelReg == DETAIL_SEL_RESET) begin
			alarmDetail <= '0;
		end else begin
			alarmDetail <= alarmHistory[(int'(detailSelReg)-1)*DATA_W +: DATA_W];
		end
	end

	always_ff @(posedge ref_clk) begin
		if (srst) begin
			userOrigin <= '0;
		end else if (accept && (cmdId == ID_ORIGIN_PRESET)) begin
			userOrigin <= tcpPosition;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (srst) begin
			driverStopRelease <= '0;
		end else if (accept && (cmdId == ID_DRV_STOP_RELEASE)) begin
			driverStopRelease <= ~driverExcluded;
		end else begin
			driverStopRelease <= '0;
		end
	end
endmodule : psmc_param_store

// >>> sim/psmc_param_store_props.sv
`timescale 1ns/1ps
module psmc_param_store_props
	import psmc_pkg::*;
(
	// Clock and reset
	input wire logic ref_clk,
	input wire logic srst,
	// Host port and inputs
	input wire logic cmdValid,
	input wire logic [psmc_pkg::ID_W-1:0] cmdId,
	input wire logic [psmc_pkg::DATA_W-1:0] cmdData,
	input wire logic [psmc_pkg::DATA_W-1:0] tcpPosition,
	input wire logic [psmc_pkg::N_DRV-1:0] driverExcluded,
	input wire logic alarmEvent,
	// Outputs watched
	input wire logic busy,
	input wire logic cmdDone,
	input wire logic cmdRefused,
	input wire logic [psmc_pkg::N_PARAM*psmc_pkg::DATA_W-1:0] appliedParams,
	input wire logic [psmc_pkg::N_PARAM*psmc_pkg::DATA_W-1:0] ramParams,
	input wire logic [psmc_pkg::N_PARAM*psmc_pkg::DATA_W-1:0] nvParams,
	input wire logic toolUnlocked,
	input wire logic [psmc_pkg::HIST_DEPTH*psmc_pkg::DATA_W-1:0] alarmHistory,
	input wire logic [psmc_pkg::DATA_W-1:0] userOrigin,
	input wire logic [psmc_pkg::N_DRV-1:0] driverStopRelease
);
	import psmc_pkg::*;
	logic take;
	assign take = cmdValid & ~busy;
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (srst);
	property p_param_ram;
		take && cmdId[15:4] == 12'h010 |=> cmdDone && ramParams[32*$past(cmdId[3:0]) +: 32] == $past(cmdData);
	endproperty
	property p_class_a;
		take && cmdId[15:2] == 14'h0040 |=> appliedParams[32*$past(cmdId[1:0]) +: 32] == $past(cmdData);
	endproperty
	property p_refuse;
		cmdValid && busy |=> cmdRefused;
	endproperty
	property p_batch;
		take && cmdId == ID_RAM_TO_NV |=> busy[*8] ##1 busy[*8] ##1 (!busy && cmdDone);
	endproperty
	property p_nv_quiet;
		!$stable(nvParams) |-> $past(busy);
	endproperty
	property p_class_d;
		!$stable(appliedParams[511:384]) |-> $past(busy);
	endproperty
	property p_key;
		take && cmdId == ID_PROTECT_KEY |=> toolUnlocked == ($past(cmdData) == PROTECT_KEY_VALUE);
	endproperty
	property p_origin;
		take && cmdId == ID_ORIGIN_PRESET |=> userOrigin == $past(tcpPosition);
	endproperty
	property p_stop_rel;
		take && cmdId == ID_DRV_STOP_RELEASE |=> driverStopRelease == ~$past(driverExcluded) ##1 driverStopRelease == 4'h0;
	endproperty
	property p_hist_clr;
		take && cmdId == ID_ALARM_HIST_CLEAR && !alarmEvent |=> alarmHistory == '0;
	endproperty
	a_param_ram: assert property (p_param_ram) else $error("ram word not written");
	a_class_a: assert property (p_class_a) else $error("class A not applied");
	a_refuse: assert property (p_refuse) else $error("busy write not refused");
	a_batch: assert property (p_batch) else $error("batch timing wrong");
	a_nv_quiet: assert property (p_nv_quiet) else $error("nv changed outside batch");
	a_class_d: assert property (p_class_d) else $error("class D applied early");
	a_key: assert property (p_key) else $error("unlock state wrong");
	a_origin: assert property (p_origin) else $error("origin not preset");
	a_stop_rel: assert property (p_stop_rel) else $error("stop release pulse wrong");
	a_hist_clr: assert property (p_hist_clr) else $error("alarm history kept");
	c_batch: cover property (take && cmdId == ID_RAM_TO_NV);
	c_refuse: cover property (cmdRefused);
	c_unlock: cover property (toolUnlocked);
endmodule : psmc_param_store_props

bind psmc_param_store psmc_param_store_props u_props (
	.ref_clk(ref_clk), .srst(srst), .cmdValid(cmdValid), .cmdId(cmdId), .cmdData(cmdData),
	.tcpPosition(tcpPosition), .driverExcluded(driverExcluded), .alarmEvent(alarmEvent), .busy(busy),
	.cmdDone(cmdDone), .cmdRefused(cmdRefused), .appliedParams(appliedParams), .ramParams(ramParams),
	.nvParams(nvParams), .toolUnlocked(toolUnlocked), .alarmHistory(alarmHistory), .userOrigin(userOrigin),
	.driverStopRelease(driverStopRelease)
);

// >>> sim/psmc_host_model.sv
`timescale 1ns/1ps
module psmc_host_model (
	// Clock and status
	input wire logic ref_clk,
	input wire logic busy,
	// Host write port
	output logic cmdValid,
	output logic [psmc_pkg::ID_W-1:0] cmdId,
	output logic [psmc_pkg::DATA_W-1:0] cmdData
);
	import psmc_pkg::*;
	initial begin
		cmdValid = 1'b0;
		cmdId = '0;
		cmdData = '0;
	end
	task automatic send(input logic [ID_W-1:0] id, input logic [DATA_W-1:0] dat, input bit noWait);
		int n;
		n = 0;
		while (!noWait && busy !== 1'b0 && n < 200) begin
			@(negedge ref_clk);
			n++;
		end
		@(posedge ref_clk);
		cmdValid <= 1'b1;
		cmdId <= id;
		cmdData <= dat;
		@(posedge ref_clk);
		cmdValid <= 1'b0;
		// Stale lines inverted, never left looking valid
		cmdId <= ~id;
		cmdData <= ~dat;
	endtask : send
endmodule : psmc_host_model

// >>> sim/psmc_param_store_tb.sv
`timescale 1ns/1ps
module psmc_param_store_tb;
	import psmc_pkg::*;
	typedef struct packed {logic [3:0] sel; logic [3:0] idx; logic [31:0] exp;} psmc_note_t;
	logic ref_clk = 1'b0, srst = 1'b1, opStopped = 1'b0, alarmEvent = 1'b0, alarmNonResettable = 1'b0;
	logic infoEvent = 1'b0, busy, cmdDone, cmdRefused, toolUnlocked, alarmActive, infoActive, cmdValid;
	logic [ID_W-1:0] cmdId;
	logic [DATA_W-1:0] cmdData, tcpPosition = '0, alarmCodeIn = '0, infoCodeIn = '0, presentAlarm, presentInfo;
	logic [DATA_W-1:0] alarmDetail, userOrigin, lfsr = 32'h0000_278e, a2;
	logic [N_DRV-1:0] driverExcluded = '0, driverStopRelease;
	logic [N_PARAM*DATA_W-1:0] appliedParams, ramParams, nvParams;
	logic [HIST_DEPTH*DATA_W-1:0] alarmHistory, infoHistory, commandHistory;
	logic [31:0] d [16];
	psmc_note_t notes [$];
	psmc_note_t nt;
	int fail_count = 0, comparisons = 0;
	bit pend = 0;
	psmc_param_store dut (.ref_clk(ref_clk), .srst(srst), .cmdValid(cmdValid), .cmdId(cmdId), .cmdData(cmdData),
		.opStopped(opStopped), .tcpPosition(tcpPosition), .driverExcluded(driverExcluded), .alarmEvent(alarmEvent),
		.alarmCodeIn(alarmCodeIn), .alarmNonResettable(alarmNonResettable), .infoEvent(infoEvent),
		.infoCodeIn(infoCodeIn), .busy(busy), .cmdDone(cmdDone), .cmdRefused(cmdRefused),
		.appliedParams(appliedParams), .ramParams(ramParams), .nvParams(nvParams), .toolUnlocked(toolUnlocked),
		.alarmActive(alarmActive), .presentAlarm(presentAlarm), .infoActive(infoActive), .presentInfo(presentInfo),
		.alarmHistory(alarmHistory), .infoHistory(infoHistory), .commandHistory(commandHistory),
		.alarmDetail(alarmDetail), .userOrigin(userOrigin), .driverStopRelease(driverStopRelease));
	psmc_host_model host (.ref_clk(ref_clk), .busy(busy), .cmdValid(cmdValid), .cmdId(cmdId), .cmdData(cmdData));
	initial begin
		forever #10 ref_clk = ~ref_clk;
	end
	function automatic logic [31:0] rnd();
		lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
		return lfsr;
	endfunction : rnd
	function automatic logic [31:0] w(input logic [511:0] v, input logic [3:0] i);
		return v[32*i +: 32];
	endfunction : w
	function automatic logic [31:0] obs(input logic [3:0] sel, input logic [3:0] i);
		case (sel)
			4'h0: return w(ramParams, i);
			4'h1: return w(appliedParams, i);
			4'h2: return w(nvParams, i);
			4'h3: return userOrigin;
			4'h4: return {31'h0, toolUnlocked};
			4'h5: return {31'h0, alarmActive};
			4'h6: return alarmHistory[31:0];
			4'h7: return alarmDetail;
			4'h8: return {31'h0, infoActive};
			4'h9: return infoHistory[31:0];
			default: return commandHistory[31:0];
		endcase
	endfunction : obs
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			fail_count++;
			$display("CHECK FAILED %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : check
	task automatic complete_run();
		$display("mismatches %0d comparisons %0d", fail_count, comparisons);
		if (fail_count == 0 && comparisons > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask : complete_run
	task automatic waitFor(input bit done);
		int n;
		n = 0;
		do begin
			@(negedge ref_clk);
			n++;
		end while ((done ? cmdDone !== 1'b1 : busy !== 1'b0) && n < 100);
		if (n >= 100) check(32'h1, 32'h0);
		repeat (2) @(negedge ref_clk);
	endtask : waitFor
	task automatic cmd(input logic [15:0] id, input logic [31:0] dat, input logic [3:0] sel, i, input logic [31:0] e);
		notes.push_back('{sel, i, e});
		host.send(id, dat, 1'b0);
		waitFor(1'b1);
	endtask : cmd
	task automatic powerUp();
		@(posedge ref_clk);
		srst <= 1'b1;
		repeat (3) @(posedge ref_clk);
		srst <= 1'b0;
		waitFor(1'b0);
	endtask : powerUp
	task automatic alarm(input logic [31:0] code, input logic nonRes);
		@(posedge ref_clk);
		alarmEvent <= 1'b1;
		alarmCodeIn <= code;
		alarmNonResettable <= nonRes;
		@(posedge ref_clk);
		alarmEvent <= 1'b0;
	endtask : alarm
	// Result seen one cycle after each completion
	always @(negedge ref_clk) begin
		if (pend) begin
			if (notes.size() == 0) check(32'h1, 32'h0);
			else begin
				nt = notes.pop_front();
				check(obs(nt.sel, nt.idx), nt.exp);
			end
		end
		pend = (cmdDone === 1'b1);
	end
	initial begin
		#(20 * 20000);
		fail_count++;
		complete_run();
	end
	initial begin
		repeat (3) @(posedge ref_clk);
		srst <= 1'b0;
		waitFor(1'b0);
		cmd(ID_INIT_KEEP_MECH, rnd(), 4'h2, 4'h2, 32'h0);
		powerUp();
		check(toolUnlocked, 1'b0);
		for (int i = 0; i < 16; i++) begin
			d[i] = rnd();
			cmd(PARAM_ID_BASE + 16'(i), d[i], 4'h0, i[3:0], d[i]);
		end
		check(w(appliedParams, 4'h2), d[2]);
		check(w(appliedParams, 4'h5), 32'h0);
		@(posedge ref_clk);
		opStopped <= 1'b1;
		@(posedge ref_clk);
		opStopped <= 1'b0;
		repeat (2) @(negedge ref_clk);
		check(w(appliedParams, 4'h5), d[5]);
		check(w(appliedParams, 4'h9), 32'h0);
		cmd(ID_RECONFIGURE, rnd(), 4'h1, 4'h9, d[9]);
		check(w(appliedParams, 4'hd), 32'h0);
		check(w(nvParams, 4'hd), 32'h0);
		notes.push_back('{4'h2, 4'hd, d[13]});
		host.send(ID_RAM_TO_NV, rnd(), 1'b0);
		host.send(PARAM_ID_BASE, rnd(), 1'b1);
		@(negedge ref_clk);
		check(cmdRefused, 1'b1);
		waitFor(1'b1);
		check(w(ramParams, 4'h0), d[0]);
		powerUp();
		check(w(appliedParams, 4'hd), d[13]);
		check(w(ramParams, 4'h7), d[7]);
		cmd(ID_INIT_KEEP_MECH_COMM, rnd(), 4'h2, 4'h3, d[3]);
		check(w(nvParams, 4'h4), 32'h0);
		cmd(ID_INIT_KEEP_MECH, rnd(), 4'h2, 4'h3, 32'h0);
		check(w(nvParams, 4'h1), d[1]);
		cmd(ID_NV_TO_RAM, rnd(), 4'h0, 4'h4, 32'h0);
		cmd(ID_PROTECT_KEY, PROTECT_KEY_VALUE, 4'h4, 4'h0, 32'h1);
		cmd(ID_PROTECT_KEY, PROTECT_KEY_VALUE ^ 32'h1, 4'h4, 4'h0, 32'h0);
		alarm(rnd(), 1'b0);
		cmd(ID_ALARM_RESET, rnd(), 4'h5, 4'h0, 32'h0);
		check(presentAlarm, 32'h0);
		alarm(rnd(), 1'b1);
		cmd(ID_ALARM_RESET, rnd(), 4'h5, 4'h0, 32'h1);
		a2 = rnd();
		alarm(a2, 1'b0);
		alarm(rnd(), 1'b0);
		cmd(ID_ALARM_DETAIL_SEL, 32'h2, 4'h7, 4'h0, a2);
		cmd(ID_ALARM_HIST_CLEAR, rnd(), 4'h6, 4'h0, 32'h0);
		@(posedge ref_clk);
		infoEvent <= 1'b1;
		infoCodeIn <= rnd();
		@(posedge ref_clk);
		infoEvent <= 1'b0;
		cmd(ID_INFO_CLEAR, rnd(), 4'h8, 4'h0, 32'h0);
		check(presentInfo, 32'h0);
		cmd(ID_INFO_HIST_CLEAR, rnd(), 4'h9, 4'h0, 32'h0);
		cmd(ID_CMD_HIST_CLEAR, rnd(), 4'ha, 4'h0, 32'h00ce);
		check(commandHistory[63:32], 32'h0);
		@(posedge ref_clk);
		tcpPosition <= rnd();
		driverExcluded <= 4'h5;
		@(negedge ref_clk);
		cmd(ID_ORIGIN_PRESET, rnd(), 4'h3, 4'h0, tcpPosition);
		cmd(ID_DRV_STOP_RELEASE, rnd(), 4'ha, 4'h0, 32'h00d0);
		check(notes.size(), 32'h0);
		complete_run();
	end
endmodule : psmc_param_store_tb
